// file: dv/nv_config_crc_and_write_lock_checker.sv
`timescale 1ns/1ps
module nv_config_crc_and_write_lock_checker
    import nvc_pkg::*;
#(
    parameter logic [7:0] VARIANT_CODE = 8'h5A
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Link signals
    input wire logic req,
    input wire logic we,
    input wire logic [6:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic [7:0] rdata,
    input wire logic forced_normal,
    input wire logic prog_ready
);
    localparam int CRC_WAIT = 64;
    logic [7:0] cfg_lo_r;
    logic [7:0] cfg_hi_r;
    logic [7:0] exp_crc;
    logic wr_lo;
    logic wr_hi;
    logic crc_wr;

    function automatic logic [7:0] crc_calc(input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] c;
        c = 8'hFF ^ lo;
        for (int j = 0; j < 16; j++)
        begin
            if (j == 8)
            begin
                c = c ^ hi;
            end
            c = c[7] ? {c[6:0], 1'b0} ^ 8'h2F : {c[6:0], 1'b0};
        end
        return c ^ 8'hFF;
    endfunction : crc_calc

    assign wr_lo = ack && we && (addr == OFF_CFG_LO);
    assign wr_hi = ack && we && (addr == OFF_CFG_HI);
    assign crc_wr = ack && we && (addr == OFF_CHECK);
    assign exp_crc = crc_calc(cfg_lo_r, cfg_hi_r);

    // Shadow of the bytes the host sent
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cfg_lo_r <= 8'h00;
            cfg_hi_r <= 8'h00;
        end
        else
        begin
            cfg_lo_r <= wr_lo ? wdata : cfg_lo_r;
            cfg_hi_r <= wr_hi ? wdata : cfg_hi_r;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence good_crc_write;
        crc_wr && prog_ready && (wdata == exp_crc);
    endsequence
    sequence bad_crc_write;
        crc_wr && ((wdata != exp_crc) || !prog_ready);
    endsequence

    a_ack_pulse: assert property (ack |=> !ack)
        else $error("answer longer than one cycle");
    a_ack_timely: assert property (req && !ack |=> ack)
        else $error("answer not one cycle after request");
    a_rdata_hold: assert property ($changed(rdata) |-> ack)
        else $error("read data moved without answer");
    a_variant_fixed: assert property (ack && !we && addr == OFF_VARIANT |-> rdata == VARIANT_CODE)
        else $error("variant byte wrong");
    a_lock_reserved: assert property (ack && addr == OFF_LOCK |-> !rdata[7])
        else $error("reserved lock bit set");
    a_ready_status: assert property (ack && !we && addr == OFF_STATUS && $stable(prog_ready) |-> rdata[STAT_READY_BIT] == prog_ready)
        else $error("status ready bit differs from flag");
    a_crc_trigger: assert property (good_crc_write |-> ##[1:CRC_WAIT] !prog_ready)
        else $error("matching check value did not program");
    a_crc_ignored: assert property (bad_crc_write |=> $stable(prog_ready) [*8])
        else $error("programming started without match or readiness");
    a_cells_protect: assert property ($fell(prog_ready) |=> !prog_ready [*8])
        else $error("cells not protected after programming");
    a_prog_forced: assert property ($fell(prog_ready) |-> forced_normal)
        else $error("programming outside forced normal");
endmodule : nv_config_crc_and_write_lock_checker

// file: dv/nv_config_crc_and_write_lock_tb.sv
`timescale 1ns/1ps
module nv_config_crc_and_write_lock_tb
    import nvc_pkg::*;
;
    localparam logic [7:0] VAR_CODE = 8'h3C; // Arbitrary value
    localparam logic [41:0] AREA_FIRST = {7'h68, 7'h50, 7'h40, 7'h30, 7'h20, 7'h10};
    localparam logic [41:0] AREA_LAST = {7'h6F, 7'h5F, 7'h4F, 7'h3F, 7'h2F, 7'h1F};
    logic clk, rst, psel, penable, pwrite, pready, pslverr, perr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, s, stat_word;
    logic bat, rstpin_n, canh, canl, ecc, rxd, clamped, sysrst, pon, area_wr;
    logic [7:0] cell_lo, cell_hi, area_wdata, q, lo, hi;
    logic [6:0] area_addr, area_last;
    logic [5:0] c0;
    int fail_count, samples_checked, area_cnt, sysrst_cnt, n0, n;

    nvc_if lnk();
    nv_config_host nv_config_host_inst (.i_clk(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(lnk));
    nv_config_device #(.RESTORE_HOLD_CYC(8), .PROG_CYC(4), .VARIANT_CODE(VAR_CODE))
    nv_config_device_inst (.i_clk(clk), .i_rst(rst), .link(lnk), .i_bat_powerup(bat),
        .i_reset_pin_low_active_n(rstpin_n), .i_canh_at_bat(canh), .i_canl_at_gnd(canl),
        .i_ecc_corrected(ecc), .o_rxd(rxd), .o_clamped_bus_receive_pin(clamped),
        .o_sys_reset(sysrst), .o_power_on_flag(pon), .o_cell_lo(cell_lo), .o_cell_hi(cell_hi),
        .o_area_wr(area_wr), .o_area_addr(area_addr), .o_area_wdata(area_wdata));
    nv_config_crc_and_write_lock_checker #(.VARIANT_CODE(VAR_CODE))
    nv_config_crc_and_write_lock_checker_inst (.i_clk(clk), .i_rst(rst), .req(lnk.req),
        .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata),
        .forced_normal(lnk.forced_normal), .prog_ready(lnk.prog_ready));

    always #5 clk = ~clk;

    always @(posedge clk)
    begin
        if (area_wr === 1'b1)
        begin
            area_cnt++;
            area_last = area_addr;
        end
        if (sysrst === 1'b1)
            sysrst_cnt++;
    end

    function automatic logic [7:0] crc_of(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] c;
        logic [15:0] d;
        c = 8'hFF;
        d = {a, b};
        for (int i = 0; i < 2; i++)
        begin
            c = c ^ d[15 - 8 * i -: 8];
            for (int j = 0; j < 8; j++)
                c = c[7] ? {c[6:0], 1'b0} ^ 8'h2F : {c[6:0], 1'b0};
        end
        return c ^ 8'hFF;
    endfunction : crc_of

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        r = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic dev(input logic w, input logic [6:0] a, input logic [7:0] d,
                       output logic [7:0] r);
        int k;
        apb(1'b1, H_OFF_CMD, {15'h0000, w, 1'b0, a, d}, stat_word);
        stat_word = 32'h1;
        k = 0;
        while (stat_word[STAT_BUSY_BIT] !== 1'b0 && k < 50)
        begin
            apb(1'b0, H_OFF_STAT, 32'h0, stat_word);
            k++;
        end
        chk(32'(k < 50), 32'h1);
        r = stat_word[STAT_RDATA_LSB +: 8];
    endtask : dev

    task automatic settle(input int cyc);
        repeat (cyc) @(posedge clk);
        #1;
    endtask : settle

    initial
    begin
        #300000;
        fail_count++;
        final_report();
    end

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {bat, canh, canl, ecc} = '0;
        rstpin_n = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        dev(1'b0, OFF_STATUS, 8'h00, q);
        c0 = q[7:2];
        chk(q[1:0], 2'b01);
        dev(1'b1, OFF_VARIANT, 8'h00, q);
        dev(1'b0, OFF_VARIANT, 8'h00, q);
        chk(q, VAR_CODE);
        dev(1'b1, OFF_LOCK, 8'hFF, q);
        dev(1'b0, OFF_LOCK, 8'h00, q);
        chk(q, 8'h7F);
        @(posedge clk) ecc <= 1'b1;
        @(posedge clk) ecc <= 1'b0;
        dev(1'b0, OFF_STATUS, 8'h00, q);
        chk(q[1:0], 2'b11);
        dev(1'b1, OFF_STATUS, 8'h00, q);
        dev(1'b0, OFF_STATUS, 8'h00, q);
        chk(q[1:0], 2'b01);
        // General-purpose bytes under lock bit 0, other areas under bits 1-6, host check code
        dev(1'b1, OFF_LOCK, 8'h00, q);
        dev(1'b1, 7'h07, 8'h96, q);
        dev(1'b1, OFF_LOCK, 8'h01, q);
        dev(1'b1, 7'h07, 8'h69, q);
        dev(1'b0, 7'h07, 8'h00, q);
        chk(q, 8'h96);
        dev(1'b1, OFF_LOCK, 8'h7E, q);
        dev(1'b1, OFF_GP_LAST, 8'h5A, q);
        dev(1'b0, OFF_GP_LAST, 8'h00, q);
        chk(q, 8'h5A);
        for (int i = 1; i < 7; i++)
        begin
            dev(1'b1, OFF_LOCK, 8'h7F ^ (8'h01 << i), q);
            n0 = area_cnt;
            dev(1'b1, AREA_FIRST[7 * (i - 1) +: 7], 8'hA5, q);
            dev(1'b1, AREA_LAST[7 * (i - 1) +: 7], 8'h5A, q);
            chk(32'(area_cnt - n0), 32'h2);
            chk(area_last, AREA_LAST[7 * (i - 1) +: 7]);
            dev(1'b1, OFF_LOCK, 8'h01 << i, q);
            n0 = area_cnt;
            dev(1'b1, AREA_FIRST[7 * (i - 1) +: 7], 8'hA5, q);
            chk(32'(area_cnt - n0), 32'h0);
        end
        dev(1'b1, OFF_LOCK, 8'h00, q);
        for (int k = 0; k < 3; k++)
        begin
            lo = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'h12;
            hi = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'h34;
            dev(1'b1, OFF_CFG_LO, lo, q);
            dev(1'b1, OFF_CFG_HI, hi, q);
            apb(1'b0, H_OFF_CRC, 32'h0, s);
            chk(s[7:0], crc_of(lo, hi));
        end
        apb(1'b1, H_OFF_CRC, 32'h0, s);
        chk(perr, 1'b1);
        // Programming: wrong check value, then right one
        apb(1'b1, H_OFF_CTRL, 32'h1, s);
        n0 = sysrst_cnt;
        dev(1'b1, OFF_CFG_LO, 8'h3C, q);
        dev(1'b1, OFF_CFG_HI, 8'hC3, q);
        dev(1'b1, OFF_CHECK, crc_of(8'h3C, 8'hC3) ^ 8'h01, q);
        settle(20);
        chk(32'(sysrst_cnt - n0), 32'h0);
        dev(1'b0, OFF_STATUS, 8'h00, q);
        chk(q, {c0, 2'b01});
        dev(1'b1, OFF_CFG_LO, 8'h3C, q);
        dev(1'b1, OFF_CFG_HI, 8'hC3, q);
        dev(1'b1, OFF_CHECK, crc_of(8'h3C, 8'hC3), q);
        n = 0;
        while (sysrst_cnt == n0 && n < 100)
        begin
            settle(1);
            n++;
        end
        settle(2);
        chk(32'(sysrst_cnt - n0), 32'h1);
        chk({cell_hi, cell_lo}, 16'hC33C);
        dev(1'b0, OFF_STATUS, 8'h00, q);
        chk(q, {c0 + 6'h01, 2'b00});
        dev(1'b1, OFF_CFG_LO, 8'h11, q);
        dev(1'b1, OFF_CFG_HI, 8'h22, q);
        dev(1'b1, OFF_CHECK, crc_of(8'h11, 8'h22), q);
        chk(stat_word[STAT_REFUSED_BIT], 1'b1);
        settle(20);
        chk({cell_hi, cell_lo}, 16'hC33C);
        // Restore held too briefly, then in full
        n0 = sysrst_cnt;
        @(posedge clk) {bat, rstpin_n, canh, canl} <= 4'b1011;
        settle(5);
        chk(rxd, 1'b1);
        chk(clamped, 1'b0);
        @(posedge clk) canl <= 1'b0;
        settle(20);
        chk({pon, rxd}, 2'b00);
        @(posedge clk) canl <= 1'b1;
        n = 0;
        while (pon !== 1'b1 && n < 60)
        begin
            settle(1);
            n++;
        end
        chk(rxd, 1'b1);
        n = 0;
        while (rxd !== 1'b0 && n < 5)
        begin
            settle(1);
            n++;
        end
        chk({pon, rxd}, 2'b10);
        chk(32'(sysrst_cnt - n0), 32'h1);
        chk(lnk.forced_normal, 1'b1);
        @(posedge clk) {bat, rstpin_n, canh, canl} <= 4'b0100;
        dev(1'b0, OFF_STATUS, 8'h00, q);
        chk(q, {c0 + 6'h02, 2'b01});
        chk({cell_hi, cell_lo}, 16'h0000);
        final_report();
    end
endmodule : nv_config_crc_and_write_lock_tb

// file: hw/crc8_step.sv
`timescale 1ns/1ps
module crc8_step
    import nvc_pkg::*;
(
    // Running value and byte
    input wire logic [7:0] i_crc,
    input wire logic [7:0] i_data,
    // Updated value
    output logic [7:0] o_crc
);
    always_comb
    begin
        o_crc = i_crc ^ i_data;
        for (int j = 0; j < 8; j++)
        begin
            if (o_crc[7])
                o_crc = {o_crc[6:0], 1'b0} ^ CRC_POLY;
            else
                o_crc = {o_crc[6:0], 1'b0};
        end
    end
endmodule : crc8_step

// file: hw/nv_config_device.sv
// The implementer's own choice: the nvc_if link port.
`timescale 1ns/1ps
module nv_config_device
    import nvc_pkg::*;
#(
    parameter int RESTORE_HOLD_CYC = RESTORE_HOLD_CYC_DEF,
    parameter int PROG_CYC = PROG_CYC_DEF,
    parameter logic [7:0] VARIANT_CODE = 8'h5A, // Arbitrary value
    parameter logic [7:0] FACTORY_LO = 8'h00,
    parameter logic [7:0] FACTORY_HI = 8'h00
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Link to host
    nvc_if.dev link,
    // Pins seen during battery power-up
    input wire logic i_bat_powerup,
    input wire logic i_reset_pin_low_active_n,
    input wire logic i_canh_at_bat,
    input wire logic i_canl_at_gnd,
    // From cell array
    input wire logic i_ecc_corrected,
    // Pins and system signals
    output logic o_rxd,
    output logic o_clamped_bus_receive_pin,
    output logic o_sys_reset,
    output logic o_power_on_flag,
    // Cells and writes to the other register areas
    output logic [7:0] o_cell_lo,
    output logic [7:0] o_cell_hi,
    output logic o_area_wr,
    output logic [6:0] o_area_addr,
    output logic [7:0] o_area_wdata
);
    if (RESTORE_HOLD_CYC < 1 || PROG_CYC < 1)
    begin : g_bad_counts
        $error("hold and programming counts must be at least one");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_PROG, ST_SYSRST} state_t;

    state_t state_r;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [31:0] cnt_r;
    logic [LOCK_BITS-1:0] lock_r;
    logic [7:0] gp_r [4];
    logic [7:0] cfg_lo_r;
    logic [7:0] cfg_hi_r;
    logic [7:0] check_r;
    logic [5:0] count_r;
    logic ecc_r;
    logic ready_r;
    logic fnm_r;
    logic ack_r;
    logic [7:0] rdata_r;
    logic rxd_r;
    logic clamped_bus_receive_pin_r;
    logic sysrst_r;
    logic po_r;
    logic restoring_r;
    logic [7:0] cell_lo_r;
    logic [7:0] cell_hi_r;
    logic area_wr_r;
    logic [6:0] area_addr_r;
    logic [7:0] area_wdata_r;

    // Synchronised pins
    wire logic pw_s = sync2_r[0];
    wire logic rstpin_n_s = sync2_r[1];
    wire logic canh_s = sync2_r[2];
    wire logic canl_s = sync2_r[3];
    wire logic restore_cond = pw_s & ~rstpin_n_s & canh_s & canl_s;
    wire logic hold_done = cnt_r >= 32'(RESTORE_HOLD_CYC - 1);
    wire logic prog_done = cnt_r >= 32'(PROG_CYC - 1);

    // Link decode
    wire logic [6:0] a = link.addr;
    wire logic wr_go = link.req & link.we & ~ack_r;
    wire logic rd_go = link.req & ~ack_r;
    wire logic in_gp = a >= OFF_GP_FIRST && a <= OFF_GP_LAST;
    wire logic in_mask = a >= OFF_MASK_FIRST && a <= OFF_MASK_LAST;
    wire logic [2:0] hi_nib = a[6:4];
    wire logic locked = (in_gp & lock_r[0])
        | (hi_nib == 3'h1 & lock_r[1]) | (hi_nib == 3'h2 & lock_r[2])
        | (hi_nib == 3'h3 & lock_r[3]) | (hi_nib == 3'h4 & lock_r[4])
        | (hi_nib == 3'h5 & lock_r[5]) | (in_mask & lock_r[6]);
    wire logic wr_ok = wr_go & ~locked;
    wire logic wr_lock = wr_ok & (a == OFF_LOCK);
    wire logic wr_stat = wr_ok & (a == OFF_STATUS);
    wire logic wr_lo = wr_ok & (a == OFF_CFG_LO);
    wire logic wr_hi = wr_ok & (a == OFF_CFG_HI);
    wire logic wr_check = wr_ok & (a == OFF_CHECK);
    wire logic wr_local = in_gp | a == OFF_LOCK | a == OFF_STATUS | a == OFF_CFG_LO
        | a == OFF_CFG_HI | a == OFF_CHECK | a == OFF_VARIANT;
    wire logic busy = state_r != ST_IDLE;

    // Check code over the two config bytes
    logic [7:0] crc_mid;
    logic [7:0] crc_end;
    crc8_step u_crc_lo (.i_crc(CRC_INIT), .i_data(cfg_lo_r), .o_crc(crc_mid));
    crc8_step u_crc_hi (.i_crc(crc_mid), .i_data(cfg_hi_r), .o_crc(crc_end));
    wire logic [7:0] crc_final = crc_end ^ CRC_XOR;
    wire logic crc_match = link.wdata == crc_final;
    wire logic prog_start = wr_check & ready_r & ~busy & crc_match;

    wire logic [5:0] count_nxt = (count_r == COUNT_MAX) ? count_r : count_r + 6'h01;

    // Read mux
    wire logic [7:0] stat_val = {count_r, ecc_r, ready_r};
    wire logic [7:0] rd_val =
        in_gp ? gp_r[2'(a - OFF_GP_FIRST)] :
        (a == OFF_LOCK) ? {1'b0, lock_r} :
        (a == OFF_STATUS) ? stat_val :
        (a == OFF_CFG_LO) ? cfg_lo_r :
        (a == OFF_CFG_HI) ? cfg_hi_r :
        (a == OFF_CHECK) ? check_r :
        (a == OFF_VARIANT) ? VARIANT_CODE : 8'h00;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end
        else
        begin
            sync1_r <= {i_canl_at_gnd, i_canh_at_bat, i_reset_pin_low_active_n, i_bat_powerup};
            sync2_r <= sync1_r;
        end
    end

    // Link handshake and host-written registers
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ack_r <= 1'b0;
            rdata_r <= 8'h00;
            lock_r <= '0;
            gp_r <= '{default: 8'h00};
            check_r <= 8'h00;
            area_wr_r <= 1'b0;
            area_addr_r <= 7'h00;
            area_wdata_r <= 8'h00;
        end
        else
        begin
            ack_r <= rd_go;
            if (rd_go)
                rdata_r <= rd_val;
            if (wr_lock)
                lock_r <= link.wdata[LOCK_BITS-1:0];
            if (wr_ok & in_gp)
                gp_r[2'(a - OFF_GP_FIRST)] <= link.wdata;
            if (wr_check)
                check_r <= link.wdata;
            area_wr_r <= wr_ok & ~wr_local;
            if (wr_ok & ~wr_local)
            begin
                area_addr_r <= a;
                area_wdata_r <= link.wdata;
            end
        end
    end

    // Cells, status, restore and programming sequence
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r <= ST_IDLE;
            cnt_r <= 32'h0;
            cfg_lo_r <= FACTORY_LO;
            cfg_hi_r <= FACTORY_HI;
            cell_lo_r <= FACTORY_LO;
            cell_hi_r <= FACTORY_HI;
            count_r <= 6'h00;
            ecc_r <= 1'b0;
            ready_r <= READY_RST;
            fnm_r <= FORCED_NORMAL_RST;
            rxd_r <= 1'b0;
            clamped_bus_receive_pin_r <= 1'b1;
            sysrst_r <= 1'b0;
            po_r <= 1'b0;
            restoring_r <= 1'b0;
        end
        else
        begin
            sysrst_r <= 1'b0;
            clamped_bus_receive_pin_r <= ~(canh_s & canl_s);
            if (i_ecc_corrected)
                ecc_r <= 1'b1;
            else if (wr_stat & ~link.wdata[STAT_ECC_BIT])
                ecc_r <= 1'b0;
            if (wr_lo & ~busy)
                cfg_lo_r <= link.wdata;
            if (wr_hi & ~busy)
                cfg_hi_r <= link.wdata;
            if (po_r)
                rxd_r <= 1'b0;
            unique case (state_r)
                ST_IDLE:
                begin
                    cnt_r <= 32'h0;
                    if (restore_cond & ~po_r)
                    begin
                        state_r <= ST_HOLD;
                        rxd_r <= 1'b1;
                        po_r <= 1'b0;
                    end
                    else if (prog_start)
                        state_r <= ST_PROG;
                end
                ST_HOLD:
                begin
                    cnt_r <= cnt_r + 32'h1;
                    if (!restore_cond)
                    begin
                        state_r <= ST_IDLE;
                        rxd_r <= 1'b0;
                    end
                    else if (hold_done)
                    begin
                        cell_lo_r <= FACTORY_LO;
                        cell_hi_r <= FACTORY_HI;
                        cfg_lo_r <= FACTORY_LO;
                        cfg_hi_r <= FACTORY_HI;
                        ready_r <= 1'b1;
                        count_r <= count_nxt;
                        restoring_r <= 1'b1;
                        state_r <= ST_SYSRST;
                    end
                end
                ST_PROG:
                begin
                    cnt_r <= cnt_r + 32'h1;
                    if (prog_done)
                    begin
                        cell_lo_r <= cfg_lo_r;
                        cell_hi_r <= cfg_hi_r;
                        count_r <= count_nxt;
                        ready_r <= 1'b0;
                        restoring_r <= 1'b0;
                        state_r <= ST_SYSRST;
                    end
                end
                ST_SYSRST:
                begin
                    sysrst_r <= 1'b1;
                    if (restoring_r)
                    begin
                        fnm_r <= 1'b1;
                        po_r <= 1'b1;
                    end
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    assign link.ack = ack_r;
    assign link.rdata = rdata_r;
    assign link.forced_normal = fnm_r;
    assign link.prog_ready = ready_r;
    assign o_rxd = rxd_r;
    assign o_clamped_bus_receive_pin = clamped_bus_receive_pin_r;
    assign o_sys_reset = sysrst_r;
    assign o_power_on_flag = po_r;
    assign o_cell_lo = cell_lo_r;
    assign o_cell_hi = cell_hi_r;
    assign o_area_wr = area_wr_r;
    assign o_area_addr = area_addr_r;
    assign o_area_wdata = area_wdata_r;
endmodule : nv_config_device

// file: hw/nv_config_host.sv
`timescale 1ns/1ps
module nv_config_host
    import nvc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Link to device
    nvc_if.host link
);
    logic req_r;
    logic we_r;
    logic [6:0] addr_r;
    logic [7:0] wdata_r;
    logic [7:0] rdata_r;
    logic refused_r;
    logic forced_normal_control_r;
    logic [7:0] sh_lo_r;
    logic [7:0] sh_hi_r;
    logic have_lo_r;
    logic have_hi_r;

    wire logic acc = i_psel & i_penable;
    wire logic a_cmd = i_paddr == H_OFF_CMD;
    wire logic a_stat = i_paddr == H_OFF_STAT;
    wire logic a_ctrl = i_paddr == H_OFF_CTRL;
    wire logic a_crc = i_paddr == H_OFF_CRC;
    wire logic mapped = a_cmd | a_stat | a_ctrl | a_crc;
    wire logic bad = ~mapped | (i_pwrite & (a_stat | a_crc)) | (i_pwrite & a_cmd & req_r);
    wire logic cmd_wr = acc & i_pwrite & a_cmd & ~req_r;
    wire logic ctrl_wr = acc & i_pwrite & a_ctrl;
    wire logic c_we = i_pwdata[CMD_WE_BIT];
    wire logic [6:0] c_addr = i_pwdata[CMD_ADDR_LSB +: 7];
    wire logic [7:0] c_data = i_pwdata[7:0];
    wire logic c_crc = c_we & (c_addr == OFF_CHECK);
    wire logic may_prog = link.forced_normal & forced_normal_control_r & link.prog_ready
        & have_lo_r & have_hi_r;
    wire logic issue = cmd_wr & (~c_crc | may_prog);

    logic [7:0] crc_mid;
    logic [7:0] crc_end;
    crc8_step u_crc_lo (.i_crc(CRC_INIT), .i_data(sh_lo_r), .o_crc(crc_mid));
    crc8_step u_crc_hi (.i_crc(crc_mid), .i_data(sh_hi_r), .o_crc(crc_end));

    wire logic [31:0] rd_val =
        a_stat ? {16'h0, rdata_r, 6'h00, refused_r, req_r} :
        a_ctrl ? {31'h0, forced_normal_control_r} :
        a_crc ? {24'h0, crc_end ^ CRC_XOR} : 32'h0;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            req_r <= 1'b0;
            we_r <= 1'b0;
            addr_r <= 7'h00;
            wdata_r <= 8'h00;
            rdata_r <= 8'h00;
            refused_r <= 1'b0;
            forced_normal_control_r <= 1'b0;
            sh_lo_r <= 8'h00;
            sh_hi_r <= 8'h00;
            have_lo_r <= 1'b0;
            have_hi_r <= 1'b0;
            o_prdata <= 32'h0;
        end
        else
        begin
            if (i_psel & ~i_penable & ~i_pwrite)
                o_prdata <= rd_val;
            if (ctrl_wr)
                forced_normal_control_r <= i_pwdata[CTRL_FORCED_NORMAL_CONTROL_BIT];
            if (cmd_wr)
                refused_r <= ~issue;
            if (issue)
            begin
                req_r <= 1'b1;
                we_r <= c_we;
                addr_r <= c_addr;
                wdata_r <= c_data;
                if (c_we & c_addr == OFF_CFG_LO)
                begin
                    sh_lo_r <= c_data;
                    have_lo_r <= 1'b1;
                end
                if (c_we & c_addr == OFF_CFG_HI)
                begin
                    sh_hi_r <= c_data;
                    have_hi_r <= 1'b1;
                end
                if (c_crc)
                begin
                    have_lo_r <= 1'b0;
                    have_hi_r <= 1'b0;
                end
            end
            else if (req_r & link.ack)
            begin
                req_r <= 1'b0;
                rdata_r <= link.rdata;
            end
        end
    end

    assign o_pready = 1'b1;
    assign o_pslverr = acc & bad;
    assign link.req = req_r;
    assign link.we = we_r;
    assign link.addr = addr_r;
    assign link.wdata = wdata_r;
endmodule : nv_config_host

// file: hw/nvc_if.sv
`timescale 1ns/1ps
interface nvc_if;
    logic req;
    logic we;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;
    logic forced_normal;
    logic prog_ready;

    modport dev (
        input req, we, addr, wdata,
        output ack, rdata, forced_normal, prog_ready
    );
    modport host (
        output req, we, addr, wdata,
        input ack, rdata, forced_normal, prog_ready
    );
endinterface : nvc_if

// file: hw/nvc_pkg.sv
// Behaviour
// - Status bits 7:2 count reprogramming cycles
// - Status bit 1 flags corrected bit failure
// - Status bit 0 ready flag, resets one
// - Host writes CRC of 0x73,0x74; device compares
// - CRC8, polynomial 0x2F, MSB first, unreflected
// - CRC starts 0xFF, result XOR 0xFF
// - Lower byte first, XOR then eight shifts
// - Restore presets after hold of four conditions
// - After restore: system reset, forced normal
// - Receive output high throughout restore
// - Clamped-bus receive output low while clamped
// - Receive output falls once power-on flag set
// - Restore also increments reprogram counter
// - Read-only variant byte at 0x7E
// - Locks block only link writes
// - Lock bits 0-2 guard 0x06-09, 0x1x, 0x2x
// - Lock bits 3-6 guard 0x3x-0x5x, 0x68-0x6F
// - Locked areas ignore writes; bit 7 reserved
// - Config bytes first; program only on match
// - Successful programming: protect cells, then reset
// - Counter saturates, never blocks programming
// - Host programs only in forced normal, ready
package nvc_pkg;
    // Device register offsets
    localparam logic [6:0] OFF_GP_FIRST = 7'h06;
    localparam logic [6:0] OFF_GP_LAST = 7'h09;
    localparam logic [6:0] OFF_LOCK = 7'h0A;
    localparam logic [6:0] OFF_STATUS = 7'h70;
    localparam logic [6:0] OFF_CFG_LO = 7'h73;
    localparam logic [6:0] OFF_CFG_HI = 7'h74;
    localparam logic [6:0] OFF_CHECK = 7'h75;
    localparam logic [6:0] OFF_VARIANT = 7'h7E;
    localparam logic [6:0] OFF_MASK_FIRST = 7'h68;
    localparam logic [6:0] OFF_MASK_LAST = 7'h6F;
    // Status fields
    localparam int STAT_COUNT_LSB = 2;
    localparam int STAT_ECC_BIT = 1;
    localparam int STAT_READY_BIT = 0;
    localparam logic READY_RST = 1'b1;
    localparam logic FORCED_NORMAL_RST = 1'b1;
    localparam logic [5:0] COUNT_MAX = 6'h3F;
    localparam int LOCK_BITS = 7;
    // Check code
    localparam logic [7:0] CRC_POLY = 8'h2F;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    localparam logic [7:0] CRC_XOR = 8'hFF;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int RESTORE_HOLD_NS = 1000000;
    localparam int RESTORE_HOLD_CYC_DEF = (RESTORE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_TIME_NS = 10000;
    localparam int PROG_CYC_DEF = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Host register offsets (APB byte addresses)
    localparam logic [7:0] H_OFF_CMD = 8'h00;
    localparam logic [7:0] H_OFF_STAT = 8'h04;
    localparam logic [7:0] H_OFF_CTRL = 8'h08;
    localparam logic [7:0] H_OFF_CRC = 8'h0C;
    localparam int CMD_WE_BIT = 16;
    localparam int CMD_ADDR_LSB = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_REFUSED_BIT = 1;
    localparam int STAT_RDATA_LSB = 8;
    localparam int CTRL_FORCED_NORMAL_CONTROL_BIT = 0;
endpackage : nvc_pkg
